// [hdl/otfs_pkg.sv]
package otfs_pkg;

  // Selection codes are 11 bits wide, enough to hold 1000 plus any base code.
  localparam int CODE_W = 11;
  localparam logic [CODE_W-1:0] CODE_LOW_OFFSET = 11'h3e8;
  localparam logic [CODE_W-1:0] CODE_UNASSIGNED = 11'h7ff;

  // Base (active-high) codes of the selectable flags.
  localparam logic [CODE_W-1:0] SEL_DRIVE_ACTIVE = 11'h000;
  localparam logic [CODE_W-1:0] SEL_BUS_SAG = 11'h003;
  localparam logic [CODE_W-1:0] SEL_SW_COMMERCIAL = 11'h00b;
  localparam logic [CODE_W-1:0] SEL_SW_SECONDARY = 11'h00c;
  localparam logic [CODE_W-1:0] SEL_SW_PRIMARY = 11'h00d;
  localparam logic [CODE_W-1:0] SEL_OUT_LIMIT_DLY = 11'h016;
  localparam logic [CODE_W-1:0] SEL_COOLER = 11'h019;
  localparam logic [CODE_W-1:0] SEL_AUTO_RESET = 11'h01a;
  localparam logic [CODE_W-1:0] SEL_UNIV_DO = 11'h01b;
  localparam logic [CODE_W-1:0] SEL_SPEED_LVL2 = 11'h01f;
  localparam logic [CODE_W-1:0] SEL_OUT_ENERGIZED = 11'h023;
  localparam logic [CODE_W-1:0] SEL_LOOP_ALARM = 11'h02a;
  localparam logic [CODE_W-1:0] SEL_LOOP_CTL = 11'h02b;
  localparam logic [CODE_W-1:0] SEL_LOOP_SLEEP = 11'h02c;
  localparam logic [CODE_W-1:0] SEL_LOW_TORQUE = 11'h02d;
  localparam logic [CODE_W-1:0] SEL_TORQUE_LVL1 = 11'h02e;
  localparam logic [CODE_W-1:0] SEL_TORQUE_LVL2 = 11'h02f;
  localparam logic [CODE_W-1:0] SEL_THERMISTOR = 11'h038;
  localparam logic [CODE_W-1:0] SEL_SPEED_LVL3 = 11'h03a;
  localparam logic [CODE_W-1:0] SEL_OPEN_WIRE = 11'h03b;
  localparam logic [CODE_W-1:0] SEL_SPEED_REACH3 = 11'h048;
  localparam logic [CODE_W-1:0] SEL_MINOR_FAULT = 11'h062;
  localparam logic [CODE_W-1:0] SEL_ANY_FAULT = 11'h063;
  localparam logic [CODE_W-1:0] SEL_SAFE_CIRCUIT = 11'h065;
  localparam logic [CODE_W-1:0] SEL_SAFE_OPEN = 11'h066;
  localparam logic [CODE_W-1:0] SEL_CHOPPER = 11'h069;

  // Number of programmable output terminals: four transistor, two relay.
  localparam int NUM_TERM = 6;

  // AXI4-Lite register map; terminal n selection sits at SEL_BASE + 4*n.
  localparam logic [7:0] REG_SEL_BASE = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h18;
  localparam logic [7:0] REG_CTRL = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_TERM = 8'h24;
  localparam logic [7:0] REG_REJECT = 8'h28;

  // Field positions in the control register.
  localparam int CTRL_TORQUE_BIT = 0;
  localparam int CTRL_VECTOR_BIT = 1;
  localparam int CTRL_UDO_BIT = 2;

  // Reset values.
  localparam logic [CODE_W-1:0] SEL_RESET = 11'h7ff;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Raw drive state feeding the running and undervoltage logic.
  typedef struct packed {
    logic outputActive;
    logic dcBraking;
    logic condensPrevent;
    logic preExcite;
    logic zeroSpeedCtl;
    logic servoLock;
    logic aboveStartFreq;
    logic belowStopFreq;
    logic busBelowLevel;
    logic uvTripped;
  } otfs_drive_t;

  // Status flags computed elsewhere in the drive.
  typedef struct packed {
    logic swCommercial;
    logic swSecondary;
    logic swPrimary;
    logic outputLimitDelayed;
    logic coolerRunning;
    logic autoResetActive;
    logic speedLevelTwoFlag;
    logic speedLevelThreeFlag;
    logic speedReachedThreeFlag;
    logic loopAlarm;
    logic loopControlActive;
    logic loopSleepStop;
    logic lowTorqueFlag;
    logic torqueLevelOneFlag;
    logic torqueLevelTwoFlag;
    logic thermistorOverheat;
    logic currentInputOpenWire;
    logic minorFaultFlag;
    logic anyFaultFlag;
    logic safeInputCircuitFault;
    logic safeInputsOpen;
    logic brakeChopperFault;
  } otfs_flags_t;

endpackage

// [hdl/otfs_selector.sv]
// Functional notes
// - Six output terminals, each with own code.
// - Active-low code is active-high code plus 1000.
// - Codes 25, 26, 27: cooler, auto-reset, universal.
// - Codes 31, 58, 72; 72 void under torque.
// - Codes 42, 43, 44 loop flags; void under torque.
// - Codes 45, 46, 47 select torque flags.
// - Code 56 selects thermistor overheat.
// - Code 59 selects current-input open wire.
// - 99 any fault, 1099 inverted, 98 minor.
// - Codes 101, 102, 105 select safety, chopper faults.
// - Reject active-low codes for switching functions.
// - Codes 0 and 35 show running state.
// - Outside vector hold, drive-active drops during braking or condensation prevention.
// - Energized flag: start-frequency set, stop-frequency clear.
// - Energized stays on in braking, pre-excite, zero-speed.
// - Vector: zero-speed or servo-lock asserts both flags.
// - Bus sag flag follows bus below level.
// - Bus sag flag holds during undervoltage trip.
// - Run command ignored while bus sag asserted.
module otfs_selector #(
  parameter int NUM_TERM = otfs_pkg::NUM_TERM
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire otfs_pkg::otfs_drive_t drive,
  input wire otfs_pkg::otfs_flags_t flags,
  input wire logic runCmd,
  output logic runCmdAccepted,
  output logic [NUM_TERM-1:0] termOut,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int CW = otfs_pkg::CODE_W;

  // Codes whose function has no inverted form.
  function automatic logic noLowForm(input logic [CW-1:0] base);
    noLowForm = (base == otfs_pkg::SEL_SW_COMMERCIAL) || (base == otfs_pkg::SEL_SW_SECONDARY)
      || (base == otfs_pkg::SEL_SW_PRIMARY);
  endfunction

  // Splits a code into its base and an active-low mark.
  function automatic logic [CW:0] splitCode(input logic [CW-1:0] code);
    if (code >= otfs_pkg::CODE_LOW_OFFSET && code != otfs_pkg::CODE_UNASSIGNED) begin
      splitCode = {1'b1, code - otfs_pkg::CODE_LOW_OFFSET};
    end else begin
      splitCode = {1'b0, code};
    end
  endfunction

  // Selected flag and whether the base code is supported at all.
  function automatic logic [1:0] pickFlag(input logic [CW-1:0] base,
      input otfs_pkg::otfs_flags_t f, input logic driveActive, input logic energized,
      input logic busSag, input logic torqueMode, input logic udoVal);
    pickFlag = 2'b00;
    unique case (base)
      otfs_pkg::SEL_DRIVE_ACTIVE: pickFlag = {1'b1, driveActive};
      otfs_pkg::SEL_OUT_ENERGIZED: pickFlag = {1'b1, energized};
      otfs_pkg::SEL_BUS_SAG: pickFlag = {1'b1, busSag};
      otfs_pkg::SEL_SW_COMMERCIAL: pickFlag = {1'b1, f.swCommercial};
      otfs_pkg::SEL_SW_SECONDARY: pickFlag = {1'b1, f.swSecondary};
      otfs_pkg::SEL_SW_PRIMARY: pickFlag = {1'b1, f.swPrimary};
      otfs_pkg::SEL_OUT_LIMIT_DLY: pickFlag = {1'b1, f.outputLimitDelayed};
      otfs_pkg::SEL_COOLER: pickFlag = {1'b1, f.coolerRunning};
      otfs_pkg::SEL_AUTO_RESET: pickFlag = {1'b1, f.autoResetActive};
      otfs_pkg::SEL_UNIV_DO: pickFlag = {1'b1, udoVal};
      otfs_pkg::SEL_SPEED_LVL2: pickFlag = {1'b1, f.speedLevelTwoFlag};
      otfs_pkg::SEL_SPEED_LVL3: pickFlag = {1'b1, f.speedLevelThreeFlag};
      otfs_pkg::SEL_SPEED_REACH3: pickFlag = {!torqueMode, f.speedReachedThreeFlag};
      otfs_pkg::SEL_LOOP_ALARM: pickFlag = {!torqueMode, f.loopAlarm};
      otfs_pkg::SEL_LOOP_CTL: pickFlag = {!torqueMode, f.loopControlActive};
      otfs_pkg::SEL_LOOP_SLEEP: pickFlag = {!torqueMode, f.loopSleepStop};
      otfs_pkg::SEL_LOW_TORQUE: pickFlag = {1'b1, f.lowTorqueFlag};
      otfs_pkg::SEL_TORQUE_LVL1: pickFlag = {1'b1, f.torqueLevelOneFlag};
      otfs_pkg::SEL_TORQUE_LVL2: pickFlag = {1'b1, f.torqueLevelTwoFlag};
      otfs_pkg::SEL_THERMISTOR: pickFlag = {1'b1, f.thermistorOverheat};
      otfs_pkg::SEL_OPEN_WIRE: pickFlag = {1'b1, f.currentInputOpenWire};
      otfs_pkg::SEL_MINOR_FAULT: pickFlag = {1'b1, f.minorFaultFlag};
      otfs_pkg::SEL_ANY_FAULT: pickFlag = {1'b1, f.anyFaultFlag};
      otfs_pkg::SEL_SAFE_CIRCUIT: pickFlag = {1'b1, f.safeInputCircuitFault};
      otfs_pkg::SEL_SAFE_OPEN: pickFlag = {1'b1, f.safeInputsOpen};
      otfs_pkg::SEL_CHOPPER: pickFlag = {1'b1, f.brakeChopperFault};
      default: pickFlag = 2'b00;
    endcase
  endfunction

  logic [CW-1:0] selCode_q [NUM_TERM];
  logic [2:0] ctrl_q;
  logic [NUM_TERM-1:0] reject_q;
  logic energized_q;
  logic busSag_q;
  logic driveActive_q;
  logic [NUM_TERM-1:0] termOut_q;
  logic runCmdAccepted_q;
  logic torqueMode;
  logic vectorMode;
  logic holdZero;

  assign torqueMode = ctrl_q[otfs_pkg::CTRL_TORQUE_BIT];
  assign vectorMode = ctrl_q[otfs_pkg::CTRL_VECTOR_BIT];
  assign holdZero = vectorMode && (drive.zeroSpeedCtl || drive.servoLock);

  // Drive-active flag: running output, but not while braking or preventing condensation unless the vector zero-speed or servo-lock hold is on.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      driveActive_q <= 1'b0;
    end else begin
      driveActive_q <= holdZero || (drive.outputActive && drive.aboveStartFreq
        && !drive.dcBraking && !drive.condensPrevent);
    end
  end

  // Output-energized flag with start/stop frequency hysteresis and hold states.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      energized_q <= 1'b0;
    end else if (holdZero || drive.dcBraking || drive.preExcite || drive.zeroSpeedCtl
        || drive.condensPrevent) begin
      energized_q <= 1'b1;
    end else if (drive.outputActive && drive.aboveStartFreq) begin
      energized_q <= 1'b1;
    end else if (!drive.outputActive || drive.belowStopFreq) begin
      energized_q <= 1'b0;
    end
  end

  // Bus sag flag: follows the bus level and holds through an undervoltage trip.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busSag_q <= 1'b0;
    end else begin
      busSag_q <= drive.busBelowLevel || drive.uvTripped;
    end
  end

  // Run command gate.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      runCmdAccepted_q <= 1'b0;
    end else begin
      runCmdAccepted_q <= runCmd && !busSag_q;
    end
  end

  // Per-terminal selection, polarity and output register.
  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    logic [CW:0] split;
    logic [1:0] pick;
    logic supported;
    logic level;
    assign split = splitCode(selCode_q[t]);
    // The universal output level comes from the control register, not from the drive.
    assign pick = pickFlag(split[CW-1:0], flags, driveActive_q, energized_q, busSag_q,
      torqueMode, ctrl_q[otfs_pkg::CTRL_UDO_BIT]);
    assign level = pick[0];
    assign supported = pick[1] && !(split[CW] && noLowForm(split[CW-1:0]));
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        termOut_q[t] <= 1'b0;
      end else begin
        termOut_q[t] <= supported && (level ^ split[CW]);
      end
    end
  end

  assign termOut = termOut_q;
  assign runCmdAccepted = runCmdAccepted_q;

  // AXI4-Lite write channel: address and data taken in either order.
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic doWrite;
  logic [7:0] wIdx;
  logic [CW:0] wSplit;

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign doWrite = awHeld_q && wHeld_q;
  assign wIdx = awAddr_q - otfs_pkg::REG_SEL_BASE;
  // Written code split once, so the refusal test reads plain bits.
  assign wSplit = splitCode(wData_q[CW-1:0]);

  // Capture address and data, then answer once both are present.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= otfs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= (awAddr_q < otfs_pkg::REG_FLAGS || awAddr_q == otfs_pkg::REG_CTRL)
          ? otfs_pkg::RESP_OKAY : otfs_pkg::RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // Selection and control registers; a refused inverted code is recorded and not stored.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        selCode_q[i] <= otfs_pkg::SEL_RESET;
      end
      ctrl_q <= otfs_pkg::CTRL_RESET;
      reject_q <= '0;
    end else if (doWrite) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        if (wIdx == 8'(4 * i) && wStrb_q[1:0] == 2'b11) begin
          if (wSplit[CW] && noLowForm(wSplit[CW-1:0])) begin
            reject_q[i] <= 1'b1;
          end else begin
            selCode_q[i] <= wData_q[CW-1:0];
            reject_q[i] <= 1'b0;
          end
        end
      end
      if (awAddr_q == otfs_pkg::REG_CTRL && wStrb_q[0]) begin
        ctrl_q <= wData_q[2:0];
      end
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  // AXI4-Lite read channel, one cycle to answer.
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;

  assign s_axi_arready = !rValid_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= otfs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rResp_q <= otfs_pkg::RESP_OKAY;
      rData_q <= 32'h0000_0000;
      if (s_axi_araddr < otfs_pkg::REG_FLAGS && s_axi_araddr[1:0] == 2'b00) begin
        rData_q <= 32'(selCode_q[s_axi_araddr[4:2]]);
      end else if (s_axi_araddr == otfs_pkg::REG_FLAGS) begin
        rData_q <= 32'(flags);
      end else if (s_axi_araddr == otfs_pkg::REG_CTRL) begin
        rData_q <= 32'(ctrl_q);
      end else if (s_axi_araddr == otfs_pkg::REG_STATUS) begin
        rData_q <= {28'h0000000, runCmdAccepted_q, busSag_q, energized_q, driveActive_q};
      end else if (s_axi_araddr == otfs_pkg::REG_TERM) begin
        rData_q <= 32'(termOut_q);
      end else if (s_axi_araddr == otfs_pkg::REG_REJECT) begin
        rData_q <= 32'(reject_q);
      end else begin
        rResp_q <= otfs_pkg::RESP_SLVERR;
      end
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

endmodule

// [tb/otfs_ext_equip.sv]
module otfs_ext_equip (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] termOut,
  output logic [5:0] seenOn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Remembers which terminals were ever energized, as a field indicator lamp would.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seenOn <= 6'h00;
    end else begin
      seenOn <= seenOn | termOut;
    end
  end
endmodule

// [tb/otfs_selector_assertions.sv]
module otfs_selector_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire otfs_pkg::otfs_drive_t drive,
  input wire logic runCmd,
  input wire logic runCmdAccepted,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the single clock domain and its reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sag_blocks_run_a: assert property (drive.busBelowLevel |=> ##1 !runCmdAccepted)
    else $error("run accepted during bus sag");
  trip_blocks_run_a: assert property (drive.uvTripped |=> ##1 !runCmdAccepted)
    else $error("run accepted during trip");
  run_accepted_a: assert property (!drive.busBelowLevel && !drive.uvTripped ##1 runCmd
    |=> runCmdAccepted)
    else $error("run not accepted with healthy bus");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
endmodule

bind otfs_selector otfs_selector_checker u_chk (.clock(clock), .rst_n(rst_n), .drive(drive),
  .runCmd(runCmd), .runCmdAccepted(runCmdAccepted), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [tb/output_terminal_function_selector_tb_top.sv]
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module output_terminal_function_selector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, runCmd = 0, runCmdAccepted;
  otfs_pkg::otfs_drive_t drive = '0;
  otfs_pkg::otfs_flags_t flags = '0;
  logic [5:0] termOut, seenOn;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int miscompares = 0, checksDone = 0, cycles = 0;
  int codes[19] = '{22, 25, 26, 31, 58, 72, 42, 43, 44, 45, 46, 47, 56, 59, 98, 99, 101, 102, 105};
  int bits[19] = '{18, 17, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
  otfs_selector dut (.clock(clock), .rst_n(rst_n), .drive(drive), .flags(flags),
    .runCmd(runCmd), .runCmdAccepted(runCmdAccepted), .termOut(termOut),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  otfs_ext_equip equip (.clock(clock), .rst_n(rst_n), .termOut(termOut), .seenOn(seenOn));
  // The clock toggles every half period of 8 ns.
  always #4 clock = ~clock;
  // One AXI4-Lite transfer; handshakes are judged on values settled before each edge.
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic [1:0] rs);
    bit ta, tw, tr, done;
    int n;
    done = 0;
    n = 0;
    @(posedge clock);
    if (wr) begin awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1; end
    else begin araddr <= a; arvalid <= 1; rready <= 1; end
    while (!done && n < 64) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      done = (bready && bvalid) || (rready && rvalid);
      rd = rdata;
      rs = wr ? bresp : rresp;
      @(posedge clock);
      n++;
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tr) arvalid <= 0;
      if (done) begin bready <= 0; rready <= 0; end
    end
    if (!done) miscompares++;
  endtask
  // Register write, checking the response code.
  task automatic wreg(input logic [7:0] a, input int d, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0] rs;
    xfer(1, a, 32'(d), rd, rs);
    `CHK(rs, er)
  endtask
  // Register read, checking data and response code.
  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0] rs;
    xfer(0, a, 32'h0, rd, rs);
    `CHK(rs, er)
    `CHK(rd, ed)
  endtask
  // Selects a code on terminal k.
  task automatic sel(input int k, input int code);
    wreg(8'(4 * k), code, otfs_pkg::RESP_OKAY);
  endtask
  // Lets the two-stage flag and terminal pipeline settle.
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  // Prints counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin miscompares++; end_sim; end
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    rchk(otfs_pkg::REG_SEL_BASE, 32'h7ff, otfs_pkg::RESP_OKAY);
    rchk(otfs_pkg::REG_CTRL, 32'h0, otfs_pkg::RESP_OKAY);
    rchk(8'h40, 32'h0, otfs_pkg::RESP_SLVERR);
    wreg(otfs_pkg::REG_FLAGS, 0, otfs_pkg::RESP_SLVERR);
    `CHK(termOut, 6'h00)
    for (int i = 0; i < 19; i++) begin
      sel(i % 6, codes[i]);
      @(posedge clock) flags <= otfs_pkg::otfs_flags_t'(22'h1 << bits[i]);
      settle();
      `CHK(termOut[i % 6], 1'b1)
      @(posedge clock) flags <= '0;
      settle();
      `CHK(termOut[i % 6], 1'b0)
      sel(i % 6, codes[i] + 1000);
      settle();
      `CHK(termOut[i % 6], 1'b1)
    end
    `CHK(seenOn, 6'h3f)
    wreg(otfs_pkg::REG_CTRL, 1, otfs_pkg::RESP_OKAY);
    sel(0, 42);
    sel(2, 1072);
    @(posedge clock) flags <= '1;
    settle();
    `CHK(termOut[0], 1'b0)
    `CHK(termOut[2], 1'b0)
    sel(0, 5);
    sel(2, 1005);
    settle();
    `CHK({termOut[2], termOut[0]}, 2'b00)
    wreg(otfs_pkg::REG_CTRL, 4, otfs_pkg::RESP_OKAY);
    sel(1, 27);
    settle();
    `CHK(termOut[1], 1'b1)
    sel(1, 1011);
    rchk(otfs_pkg::REG_REJECT, 32'h2, otfs_pkg::RESP_OKAY);
    rchk(8'h04, 32'h1b, otfs_pkg::RESP_OKAY);
    wreg(otfs_pkg::REG_CTRL, 0, otfs_pkg::RESP_OKAY);
    sel(0, 0);
    sel(1, 35);
    sel(2, 3);
    sel(3, 1000);
    @(posedge clock) begin drive.outputActive <= 1; drive.aboveStartFreq <= 1; end
    settle();
    `CHK(termOut[3:0], 4'h3)
    @(posedge clock) drive.dcBraking <= 1;
    settle();
    `CHK(termOut[1:0], 2'b10)
    @(posedge clock) begin drive.dcBraking <= 0; drive.aboveStartFreq <= 0; end
    settle();
    `CHK(termOut[1], 1'b1)
    @(posedge clock) drive.belowStopFreq <= 1;
    settle();
    `CHK(termOut[3:0], 4'h8)
    wreg(otfs_pkg::REG_CTRL, 2, otfs_pkg::RESP_OKAY);
    @(posedge clock) begin drive.belowStopFreq <= 0; drive.servoLock <= 1; end
    settle();
    `CHK(termOut[1:0], 2'b11)
    @(posedge clock) begin
      drive.outputActive <= 0;
      drive.servoLock <= 0;
      drive.busBelowLevel <= 1;
      runCmd <= 1;
    end
    settle();
    `CHK({termOut[2], runCmdAccepted}, 2'b10)
    @(posedge clock) begin drive.busBelowLevel <= 0; drive.uvTripped <= 1; end
    settle();
    `CHK({termOut[2], runCmdAccepted}, 2'b10)
    @(posedge clock) drive.uvTripped <= 0;
    settle();
    `CHK({termOut[2], runCmdAccepted}, 2'b01)
    rchk(otfs_pkg::REG_TERM, 32'h8, otfs_pkg::RESP_OKAY);
    // Status read with a late read-ready, so the answer must stand meanwhile.
    @(posedge clock) begin araddr <= otfs_pkg::REG_STATUS; arvalid <= 1; end
    @(posedge clock) arvalid <= 0;
    repeat (2) @(posedge clock);
    `CHK(rvalid, 1'b1)
    rready <= 1;
    @(posedge clock) rready <= 0;
    `CHK(rdata, 32'h8)
    end_sim;
  end
endmodule
